// *** hdl/eic_pkg.sv ***
package eic_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int unsigned EIC_LINES      = 8;
  localparam int unsigned EIC_ADDR_W     = 12;
  localparam int unsigned EIC_DATA_W     = 16;
  localparam int unsigned EIC_PER_REG    = 4;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] EIC_CFG_LO_OFS = 12'hA20;
  localparam logic [11:0] EIC_CFG_HI_OFS = 12'hA24;
  localparam logic [11:0] EIC_CLEAR_OFS  = 12'hA30;
  localparam logic [11:0] EIC_STATUS_OFS = 12'hA34;
  localparam logic [11:0] EIC_MASK_OFS   = 12'hA38;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] EIC_CFG_RST    = 16'h0000;
  localparam logic [15:0] EIC_CLEAR_RST  = 16'hC000;
  localparam logic [7:0]  EIC_STATUS_RST = 8'h00;
  localparam logic [7:0]  EIC_MASK_RST   = 8'h00;

  // ----------------------------------------------------------------
  // Field layout: each line owns one nibble
  // ----------------------------------------------------------------
  localparam int unsigned EIC_NIB_W      = 4;
  localparam int unsigned EIC_MODE_LSB   = 0;
  localparam int unsigned EIC_MODE_W     = 3;
  localparam int unsigned EIC_EN_BIT     = 3;
  localparam int unsigned EIC_CLR_KEEP_LSB = 8;

  // ----------------------------------------------------------------
  // Trigger mode codes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    EIC_MODE_RISE    = 3'h0,
    EIC_MODE_FALL    = 3'h1,
    EIC_MODE_BOTH    = 3'h2,
    EIC_MODE_HIGH    = 3'h3,
    EIC_MODE_LOW     = 3'h4,
    EIC_MODE_FALL_B  = 3'h5,
    EIC_MODE_BOTH_B  = 3'h6,
    EIC_MODE_HIGH_B  = 3'h7
  } eic_mode_t;

  // Detection kind after folding alias codes
  typedef enum logic [2:0] {
    EIC_DET_RISE = 3'h0,
    EIC_DET_FALL = 3'h1,
    EIC_DET_BOTH = 3'h2,
    EIC_DET_HIGH = 3'h3,
    EIC_DET_LOW  = 3'h4
  } eic_det_t;

  // Folds alias mode codes onto their base detection
  function automatic eic_det_t eic_fold_mode(input logic [2:0] mode);
    eic_det_t det;
    det = EIC_DET_RISE;
    case (mode)
      EIC_MODE_RISE:   det = EIC_DET_RISE;
      EIC_MODE_FALL:   det = EIC_DET_FALL;
      EIC_MODE_FALL_B: det = EIC_DET_FALL;
      EIC_MODE_BOTH:   det = EIC_DET_BOTH;
      EIC_MODE_BOTH_B: det = EIC_DET_BOTH;
      EIC_MODE_HIGH:   det = EIC_DET_HIGH;
      EIC_MODE_HIGH_B: det = EIC_DET_HIGH;
      EIC_MODE_LOW:    det = EIC_DET_LOW;
      default:         det = EIC_DET_RISE;
    endcase
    return det;
  endfunction

endpackage

// *** hdl/eic_line_detect.sv ***
`timescale 1ns/1ps
`default_nettype none

module eic_line_detect
  import eic_pkg::*;
(
  // Clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst,
  // Pin and configuration
  input  wire logic       i_pin,
  input  wire logic       i_enable,
  input  wire logic [2:0] i_mode,
  // Detection
  output logic            o_event
);

  // ----------------------------------------------------------------
  // Pin synchroniser and history
  // ----------------------------------------------------------------
  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;
  logic rise;
  logic fall;
  eic_det_t det;

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg  <= 1'b0;
    end
    else
    begin
      sync1_reg <= i_pin;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  assign rise = sync2_reg & ~prev_reg;
  assign fall = ~sync2_reg & prev_reg;
  assign det  = eic_fold_mode(i_mode);

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  always_comb
  begin
    o_event = 1'b0;
    case (det)
      EIC_DET_RISE: o_event = rise;
      EIC_DET_FALL: o_event = fall;
      EIC_DET_BOTH: o_event = rise | fall;
      EIC_DET_HIGH: o_event = sync2_reg;
      EIC_DET_LOW:  o_event = ~sync2_reg;
      default:      o_event = 1'b0;
    endcase
    if (!i_enable)
    begin
      o_event = 1'b0;
    end
  end

endmodule

`default_nettype wire

// *** hdl/eic_top.sv ***
// Functional notes
// - Mode 001 falling, 010 either edge, 011 high level, 100 low level.
// - Mode 101 detects falling edges like 001.
// - Mode 110 detects both edges like 010.
// - Mode 111 flags high level like 011.
// - Low config bit 3 enables line 0; resets to zero.
// - Disabled line 0 gives no interrupt and no wake-up.
// - Enabled line 0 wakes the device from hibernate on its trigger.
// - Low config bits 2:0 hold line 0 mode; reset zero.
// - High config register at 0xA24, reset 0x0000.
// - High config bit 15 enables line 7 interrupts and wake.
// - High config bits 14:12 hold line 7 mode; 000 is rising.
// - Writing one to line 7 enable turns on its detection.
// - Low config bits 6:4 hold line 1 mode.
// - Clear register at 0xA30, reset 0xC000, clears latched events.
`timescale 1ns/1ps
`default_nettype none

module eic_top
  import eic_pkg::*;
#(
  parameter int unsigned LINES = EIC_LINES
)
(
  // Clock and reset
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_rst,
  // Register port
  input  wire logic [EIC_ADDR_W-1:0] i_addr,
  input  wire logic [EIC_DATA_W-1:0] i_wr_data,
  input  wire logic                  i_wr_stb,
  input  wire logic                  i_rd_stb,
  output logic      [EIC_DATA_W-1:0] o_rd_data,
  // External pins
  input  wire logic [LINES-1:0]      i_ext_pin,
  // Power state
  input  wire logic                  i_hibernate,
  // Events out
  output logic      [LINES-1:0]      o_line_event,
  output logic                       o_wake,
  output logic                       o_irq
);

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [EIC_DATA_W-1:0] cfg_lo_reg;
  logic [EIC_DATA_W-1:0] cfg_hi_reg;
  logic [EIC_DATA_W-1:0] clear_reg;
  logic [LINES-1:0]      status_reg;
  logic [LINES-1:0]      status_next;
  logic [LINES-1:0]      status_clr;
  logic [LINES-1:0]      irq_pending;
  logic [LINES-1:0]      mask_reg;
  logic [EIC_DATA_W-1:0] rd_data_reg;
  logic [EIC_DATA_W-1:0] rd_data_next;

  // ----------------------------------------------------------------
  // Detector wiring and registered events
  // ----------------------------------------------------------------
  logic [2*EIC_DATA_W-1:0] cfg_all;
  logic [LINES-1:0]      line_event;
  logic [LINES-1:0]      line_enable;
  logic                  wake_reg;
  logic [LINES-1:0]      event_reg;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic addr_hit
  (
    input logic [EIC_ADDR_W-1:0] addr,
    input logic [EIC_ADDR_W-1:0] ofs
  );
    return (addr == ofs);
  endfunction

  logic wr_cfg_lo;
  logic wr_cfg_hi;
  logic wr_clear;
  logic wr_mask;

  assign wr_cfg_lo = i_wr_stb && addr_hit(i_addr, EIC_CFG_LO_OFS);
  assign wr_cfg_hi = i_wr_stb && addr_hit(i_addr, EIC_CFG_HI_OFS);
  assign wr_clear  = i_wr_stb && addr_hit(i_addr, EIC_CLEAR_OFS);
  assign wr_mask   = i_wr_stb && addr_hit(i_addr, EIC_MASK_OFS);

  // ----------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------
  logic rd_cfg_lo;
  logic rd_cfg_hi;
  logic rd_clear;
  logic rd_status;
  logic rd_mask;

  assign rd_cfg_lo = i_rd_stb && addr_hit(i_addr, EIC_CFG_LO_OFS);
  assign rd_cfg_hi = i_rd_stb && addr_hit(i_addr, EIC_CFG_HI_OFS);
  assign rd_clear  = i_rd_stb && addr_hit(i_addr, EIC_CLEAR_OFS);
  assign rd_status = i_rd_stb && addr_hit(i_addr, EIC_STATUS_OFS);
  assign rd_mask   = i_rd_stb && addr_hit(i_addr, EIC_MASK_OFS);

  // ----------------------------------------------------------------
  // Low configuration register
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      cfg_lo_reg <= EIC_CFG_RST;
    end
    else if (wr_cfg_lo)
    begin
      cfg_lo_reg <= i_wr_data;
    end
  end

  // ----------------------------------------------------------------
  // High configuration register
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      cfg_hi_reg <= EIC_CFG_RST;
    end
    else if (wr_cfg_hi)
    begin
      cfg_hi_reg <= i_wr_data;
    end
  end

  // ----------------------------------------------------------------
  // Clear register: upper byte stored, lower byte acts as pulses
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      clear_reg <= EIC_CLEAR_RST;
    end
    else if (wr_clear)
    begin
      clear_reg <= {i_wr_data[EIC_DATA_W-1:EIC_CLR_KEEP_LSB], 8'h00};
    end
  end

  // ----------------------------------------------------------------
  // Mask register
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      mask_reg <= LINES'(EIC_MASK_RST);
    end
    else if (wr_mask)
    begin
      mask_reg <= i_wr_data[LINES-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Both config words, one nibble per line
  // ----------------------------------------------------------------
  assign cfg_all = {cfg_hi_reg, cfg_lo_reg};

  // ----------------------------------------------------------------
  // Per-line detectors
  // ----------------------------------------------------------------

  genvar g;
  generate
    for (g = 0; g < LINES; g = g + 1)
    begin : g_line
      assign line_enable[g] = cfg_all[g*EIC_NIB_W + EIC_EN_BIT];

      eic_line_detect u_detect
      (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_pin     (i_ext_pin[g]),
        .i_enable  (line_enable[g]),
        .i_mode    (cfg_all[g*EIC_NIB_W + EIC_MODE_LSB +: EIC_MODE_W]),
        .o_event   (line_event[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Registered event outputs
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      event_reg <= '0;
    end
    else
    begin
      event_reg <= line_event;
    end
  end

  // ----------------------------------------------------------------
  // Wake request while in hibernate
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      wake_reg <= 1'b0;
    end
    else
    begin
      wake_reg <= i_hibernate && (|line_event);
    end
  end

  // ----------------------------------------------------------------
  // Status clear sources: status read and clear register write
  // ----------------------------------------------------------------
  always_comb
  begin
    status_clr = '0;
    if (rd_status)
    begin
      status_clr = '1;
    end
    if (wr_clear)
    begin
      status_clr = status_clr | i_wr_data[LINES-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Sticky status: set wins over read clear and clear register
  // ----------------------------------------------------------------
  assign status_next = (status_reg & ~status_clr) | line_event;

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      status_reg <= LINES'(EIC_STATUS_RST);
    end
    else
    begin
      status_reg <= status_next;
    end
  end

  // ----------------------------------------------------------------
  // Read mux, data valid for one cycle
  // ----------------------------------------------------------------
  always_comb
  begin
    rd_data_next = '0;
    if (rd_cfg_lo)
    begin
      rd_data_next = cfg_lo_reg;
    end
    if (rd_cfg_hi)
    begin
      rd_data_next = cfg_hi_reg;
    end
    if (rd_clear)
    begin
      rd_data_next = clear_reg;
    end
    if (rd_status)
    begin
      rd_data_next = {{(EIC_DATA_W-LINES){1'b0}}, status_reg};
    end
    if (rd_mask)
    begin
      rd_data_next = {{(EIC_DATA_W-LINES){1'b0}}, mask_reg};
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      rd_data_reg <= '0;
    end
    else
    begin
      rd_data_reg <= rd_data_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_rd_data    = rd_data_reg;
  assign o_line_event = event_reg;
  assign o_wake       = wake_reg;

  // ----------------------------------------------------------------
  // Interrupt output: any unmasked sticky bit
  // ----------------------------------------------------------------
  assign irq_pending  = status_reg & mask_reg;
  assign o_irq        = |irq_pending;

endmodule

`default_nettype wire

// *** verif/eic_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module eic_assertions
  import eic_pkg::*;
#(
  parameter int unsigned LINES = EIC_LINES
)
(
  input wire logic                  i_sys_clk,
  input wire logic                  i_rst,
  input wire logic [EIC_ADDR_W-1:0] i_addr,
  input wire logic [EIC_DATA_W-1:0] i_wr_data,
  input wire logic                  i_wr_stb,
  input wire logic                  i_rd_stb,
  input wire logic [EIC_DATA_W-1:0] o_rd_data,
  input wire logic [LINES-1:0]      i_ext_pin,
  input wire logic                  i_hibernate,
  input wire logic [LINES-1:0]      o_line_event,
  input wire logic                  o_wake,
  input wire logic                  o_irq
);
  // ------
  // Config shadows
  // ------
  logic [15:0] lo_reg;
  logic [15:0] hi_reg;
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      lo_reg <= EIC_CFG_RST;
      hi_reg <= EIC_CFG_RST;
    end
    else if (i_wr_stb && i_addr == EIC_CFG_LO_OFS)
      lo_reg <= i_wr_data;
    else if (i_wr_stb && i_addr == EIC_CFG_HI_OFS)
      hi_reg <= i_wr_data;
  end
  wire logic en0 = lo_reg[3];
  wire logic en7 = hi_reg[15];
  wire logic hi0 = en0 && (lo_reg[2:0] == 3'h3 || lo_reg[2:0] == 3'h7);
  wire logic lw0 = en0 && lo_reg[2:0] == 3'h4;
  wire logic fl0 = en0 && (lo_reg[2:0] == 3'h1 || lo_reg[2:0] == 3'h5);
  wire logic rs7 = en7 && hi_reg[14:12] == 3'h0;
  // ------
  // Checks
  // ------
  default clocking @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);
  sequence fall0_s;
    fl0 && $fell(i_ext_pin[0]) ##1 (fl0 && !i_ext_pin[0])[*3];
  endsequence
  sequence rise7_s;
    rs7 && $rose(i_ext_pin[7]) ##1 (rs7 && i_ext_pin[7])[*3];
  endsequence
  rd_hi_a: assert property (i_rd_stb && i_addr == EIC_CFG_HI_OFS |=> o_rd_data == $past(hi_reg))
    else $error("config high read mismatch");
  wake_hib_a: assert property (o_wake |-> $past(i_hibernate))
    else $error("wake outside hibernate");
  dis0_a: assert property ((!en0)[*4] |-> !o_line_event[0])
    else $error("disabled line 0 flagged");
  dis7_a: assert property ((!en7)[*4] |-> !o_line_event[7])
    else $error("disabled line 7 flagged");
  rise7_a: assert property (rise7_s |-> o_line_event[7] ##1 !o_line_event[7])
    else $error("line 7 rising pulse wrong");
  fall0_a: assert property (fall0_s |-> o_line_event[0] ##1 !o_line_event[0])
    else $error("line 0 falling pulse wrong");
  high0_a: assert property ((hi0 && i_ext_pin[0])[*4] |-> o_line_event[0])
    else $error("line 0 high level lost");
  low0_a: assert property ((lw0 && !i_ext_pin[0])[*4] |-> o_line_event[0])
    else $error("line 0 low level lost");
endmodule
bind eic_top eic_assertions #(.LINES(LINES)) eic_assertions_i (
  .i_sys_clk   (i_sys_clk),
  .i_rst       (i_rst),
  .i_addr      (i_addr),
  .i_wr_data   (i_wr_data),
  .i_wr_stb    (i_wr_stb),
  .i_rd_stb    (i_rd_stb),
  .o_rd_data   (o_rd_data),
  .i_ext_pin   (i_ext_pin),
  .i_hibernate (i_hibernate),
  .o_line_event(o_line_event),
  .o_wake      (o_wake),
  .o_irq       (o_irq)
);
`default_nettype wire

// *** verif/eic_pin_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module eic_pin_model
  import eic_pkg::*;
(
  input  wire logic [EIC_LINES-1:0] i_level,
  input  wire logic                 i_sys_clk,
  output var logic  [EIC_LINES-1:0] o_ext_pin
);
  // Pins move just after an edge
  initial o_ext_pin = '0;
  always @(posedge i_sys_clk)
  begin
    o_ext_pin <= i_level;
  end
endmodule
`default_nettype wire

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import eic_pkg::*;
;
  logic        i_sys_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic [11:0] i_addr = '0;
  logic [15:0] i_wr_data = '0;
  logic        i_wr_stb = 1'b0;
  logic        i_rd_stb = 1'b0;
  logic        i_hibernate = 1'b0;
  logic [7:0]  lvl = '0;
  logic [7:0]  i_ext_pin;
  logic [15:0] o_rd_data;
  logic [7:0]  o_line_event;
  logic        o_wake;
  logic        o_irq;
  logic [15:0] d;
  logic [2:0]  m;
  logic        en;
  int          n_errors = 0;
  int          compares = 0;
  int          seed = 32'he2b7;
  int          ev;
  int          wk;
  eic_top #(.LINES(8)) eic_top_i (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wr_data(i_wr_data), .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb), .o_rd_data(o_rd_data),
    .i_ext_pin(i_ext_pin), .i_hibernate(i_hibernate), .o_line_event(o_line_event),
    .o_wake(o_wake), .o_irq(o_irq));
  eic_pin_model eic_pin_model_i (.i_level(lvl), .i_sys_clk(i_sys_clk), .o_ext_pin(i_ext_pin));
  initial forever #20 i_sys_clk = ~i_sys_clk;
  // ------
  // Helpers
  // ------
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_cnt(input int got, input int exp);
    compares++;
    if (got != exp)
    begin
      n_errors++;
      $display("unexpected at %0t: class %0d want %0d", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [15:0] v);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_wr_data <= v;
    i_wr_stb <= 1'b1;
    @(posedge i_sys_clk);
    i_wr_stb <= 1'b0;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [15:0] exp);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_rd_stb <= 1'b1;
    @(posedge i_sys_clk);
    i_rd_stb <= 1'b0;
    #1;
    chk_val(o_rd_data, exp);
  endtask
  task automatic win(input int ln, input logic [7:0] l);
    ev = 0;
    wk = 0;
    @(posedge i_sys_clk);
    lvl <= l;
    repeat (8)
    begin
      @(posedge i_sys_clk);
      #1;
      ev += int'(o_line_event[ln] === 1'b1);
      wk += int'(o_wake === 1'b1);
    end
  endtask
  function automatic int cls(input int n);
    return (n > 1) ? 2 : n;
  endfunction
  function automatic int exp_ev(input logic [2:0] md, input logic e, input logic up);
    if (!e)
      return 0;
    case (md)
      3'h0: return up ? 1 : 0;
      3'h1, 3'h5: return up ? 0 : 1;
      3'h2, 3'h6: return 1;
      default: return 2;
    endcase
  endfunction
  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ------
  // Sequence
  // ------
  initial
  begin
    repeat (3) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    rd_chk(EIC_CFG_LO_OFS, 16'h0000);
    rd_chk(EIC_CFG_HI_OFS, 16'h0000);
    rd_chk(EIC_CLEAR_OFS, 16'hC000);
    $display("test reset done");
    repeat (6)
    begin
      d = 16'($random(seed));
      wr(EIC_CFG_LO_OFS, d);
      rd_chk(EIC_CFG_LO_OFS, d);
      wr(EIC_CFG_HI_OFS, ~d);
      rd_chk(EIC_CFG_HI_OFS, ~d);
    end
    $display("test random config done");
    for (int ln = 0; ln < 8; ln += 7)
      for (int k = 0; k < 16; k++)
      begin
        m = k[2:0];
        en = k[3];
        wr(EIC_CFG_LO_OFS, (ln == 0) ? {12'h000, en, m} : 16'h0000);
        i_hibernate <= 1'b0;
        wr(EIC_CFG_HI_OFS, (ln == 7) ? {en, m, 12'h000} : 16'h0000);
        i_hibernate <= 1'b1;
        win(ln, 8'h81);
        chk_cnt(cls(ev), exp_ev(m, en, 1'b1));
        chk_cnt(cls(wk), exp_ev(m, en, 1'b1));
        win(ln, 8'h00);
        chk_cnt(cls(ev), exp_ev(m, en, 1'b0));
        chk_cnt(cls(wk), exp_ev(m, en, 1'b0));
      end
    $display("test mode sweep done");
    wr(EIC_CFG_LO_OFS, 16'h0000);
    i_hibernate <= 1'b0;
    wr(EIC_CFG_HI_OFS, 16'h8000);
    wr(EIC_MASK_OFS, 16'h0000);
    wr(EIC_CLEAR_OFS, 16'hC0FF);
    win(7, 8'h80);
    chk_val({15'h0000, o_irq}, 16'h0000);
    wr(EIC_MASK_OFS, 16'h0080);
    #1;
    chk_val({15'h0000, o_irq}, 16'h0001);
    rd_chk(EIC_STATUS_OFS, 16'h0080);
    chk_val({15'h0000, o_irq}, 16'h0000);
    rd_chk(EIC_STATUS_OFS, 16'h0000);
    win(7, 8'h00);
    win(7, 8'h80);
    wr(EIC_CLEAR_OFS, 16'hC080);
    rd_chk(EIC_STATUS_OFS, 16'h0000);
    rd_chk(EIC_CLEAR_OFS, 16'hC000);
    wr(12'h000, 16'hFFFF);
    rd_chk(12'h000, 16'h0000);
    $display("test interrupt done");
    end_sim();
  end
endmodule
`default_nettype wire
